// [pkg/pfbm_pkg.sv]
// Constants, field layout and carrier types for the parallel flash host controller.
// Assumes one 40 MHz clock and a byte-wide flash whose pins are sampled synchronously.
package pfbm_pkg;

    // ==========================================================
    // Clock and pin timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_ACC_NS      = 70;   // Address or enable access time
    localparam int T_WP_NS       = 35;   // Write strobe low time
    localparam int T_RP_NS       = 500;  // Hard reset low time, longer than the minimum
    localparam int ACC_CYC       = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC        = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_CYC        = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int CNT_W         = 8;

    // ==========================================================
    // Register byte offsets on the Wishbone port
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // CTRL fields: op in bits 2:0 starts a bus action, the rest are levels
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_BOTTOM = 3;
    localparam int CTRL_HV_RST = 4;
    localparam int CTRL_HV_ID  = 5;

    // STATUS fields
    localparam int ST_BUSY    = 0;
    localparam int ST_RB      = 1;
    localparam int ST_ERR     = 2;
    localparam int ST_IDMODE  = 3;
    localparam int ST_SEC_LSB = 4;

    // Operation codes written to CTRL
    localparam logic [2:0] OP_NONE   = 3'h0;
    localparam logic [2:0] OP_READ   = 3'h1;
    localparam logic [2:0] OP_WRITE  = 3'h2;
    localparam logic [2:0] OP_HRESET = 3'h3;

    // Flash command codes
    localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_RESET   = 8'hF0;
    localparam logic [7:0] CMD_IDENT   = 8'h90;
    localparam logic [7:0] CMD_PROG    = 8'hA0;
    localparam logic [7:0] CMD_ERASE   = 8'h80;
    localparam logic [7:0] CMD_CHIP    = 8'h10;
    localparam logic [7:0] CMD_SECTOR  = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_PROT1   = 8'h60;
    localparam logic [7:0] CMD_PROT2   = 8'h40;

    // Command sequence phases
    localparam logic [2:0] PH_IDLE  = 3'h0;
    localparam logic [2:0] PH_UNL1  = 3'h1;
    localparam logic [2:0] PH_UNL2  = 3'h2;
    localparam logic [2:0] PH_PDATA = 3'h3;
    localparam logic [2:0] PH_ERA1  = 3'h4;
    localparam logic [2:0] PH_ERA2  = 3'h5;
    localparam logic [2:0] PH_ERA3  = 3'h6;

    localparam int ADDR_W = 18;
    localparam int SEC_HI = 17;  // Byte address bits of the sector select lines
    localparam int SEC_LO = 13;

    // Flash pin drive, all from flip-flops
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        dq;
        logic              dq_oe_n;  // Low while the host drives the data pins
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              rst_n;
        logic              hv_rst;   // Request elevated level on the reset pin
        logic              hv_id;    // Request elevated level on the id address pin
    } pfbm_pin_type;

    localparam pfbm_pin_type PIN_RESET = '{addr: '0, dq: 8'h00, dq_oe_n: 1'b1,
        ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, hv_rst: 1'b0, hv_id: 1'b0};

endpackage

// [verilog/pfbm_sector_dec.sv]
// Sector number decode from the five sector select lines, both boot variants.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module pfbm_sector_dec
    import pfbm_pkg::*;
(
    input  wire logic [4:0] sector_select_bits_i,
    input  wire logic       bottom_i,
    output logic      [2:0] sector_number_o
);

    // ==========================================================
    // Decode
    always_comb begin
        if (bottom_i) begin
            casez (sector_select_bits_i)
                5'b0000?: sector_number_o = 3'h0;
                5'b00010: sector_number_o = 3'h1;
                5'b00011: sector_number_o = 3'h2;
                5'b001??: sector_number_o = 3'h3;
                5'b01???: sector_number_o = 3'h4;
                5'b10???: sector_number_o = 3'h5;
                default:  sector_number_o = 3'h6;
            endcase
        end else begin
            casez (sector_select_bits_i)
                5'b00???: sector_number_o = 3'h0;
                5'b01???: sector_number_o = 3'h1;
                5'b10???: sector_number_o = 3'h2;
                5'b110??: sector_number_o = 3'h3;
                5'b11100: sector_number_o = 3'h4;
                5'b11101: sector_number_o = 3'h5;
                default:  sector_number_o = 3'h6;
            endcase
        end
    end

endmodule

// [verilog/pfbm_ctrl.sv]
// Host controller for a byte-wide asynchronous NOR flash, run from a Wishbone register set.
// Assumes flash inputs are synchronous to clk_i and a board buffer resolves the data pins.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module pfbm_ctrl
    import pfbm_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    output pfbm_pin_type      pins_o,
    input  wire logic [7:0]   dq_i,
    input  wire logic         ready_busy_n_i
);

    typedef enum {S_IDLE, S_READ, S_RD_END, S_WR_SET, S_WR_PULSE, S_WR_END,
                  S_RST_PULSE, S_RST_WAIT} pfbm_state_type;

    // ==========================================================
    // Helpers
    // Byte-lane merge of a Wishbone write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Next command phase, or {1'b0,...} for a code that is not defined here
    function automatic logic [4:0] cmd_step(input logic [2:0] ph, input logic [7:0] d,
                                            input logic hv);
        logic [4:0] r;  // {ok, id_enter, phase}
        r = {2'b00, PH_IDLE};
        case (ph)
            PH_IDLE: begin
                if (d == CMD_UNLOCK1) begin
                    r = {2'b10, PH_UNL1};
                end else if (d == CMD_RESET || d == CMD_SUSPEND || d == CMD_SECTOR) begin
                    r = {2'b10, PH_IDLE};
                end else if (hv && (d == CMD_PROT1 || d == CMD_PROT2)) begin
                    r = {2'b10, PH_IDLE};
                end
            end
            PH_UNL1:  r = (d == CMD_UNLOCK2) ? {2'b10, PH_UNL2} : r;
            PH_UNL2: begin
                if (d == CMD_IDENT) begin
                    r = {2'b11, PH_IDLE};
                end else if (d == CMD_PROG) begin
                    r = {2'b10, PH_PDATA};
                end else if (d == CMD_ERASE) begin
                    r = {2'b10, PH_ERA1};
                end
            end
            PH_PDATA: r = {2'b10, PH_IDLE};
            PH_ERA1:  r = (d == CMD_UNLOCK1) ? {2'b10, PH_ERA2} : r;
            PH_ERA2:  r = (d == CMD_UNLOCK2) ? {2'b10, PH_ERA3} : r;
            PH_ERA3:  r = (d == CMD_CHIP || d == CMD_SECTOR) ? {2'b10, PH_IDLE} : r;
            default:  r = {2'b00, PH_IDLE};
        endcase
        return r;
    endfunction

    // ==========================================================
    // Register file state
    logic [5:3]        ctrl_r, ctrl_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [7:0]        wdata_r, wdata_nxt;
    logic              err_r, err_nxt;
    logic              ack_r, ack_nxt;
    logic [31:0]       dat_r, dat_nxt;
    logic [2:0]        op_r, op_nxt;
    // Sequencer state
    pfbm_state_type    state_r, state_nxt;
    logic [CNT_W-1:0]  cnt_r, cnt_nxt;
    pfbm_pin_type      pins_r, pins_nxt;
    logic [7:0]        rdata_r, rdata_nxt;
    logic [2:0]        phase_r, phase_nxt;
    logic              idm_r, idm_nxt;
    logic              seq_err;
    logic [2:0]        sector_num;
    logic [4:0]        step;
    logic [31:0]       wmerge;

    pfbm_sector_dec u_dec (
        .sector_select_bits_i (addr_r[SEC_HI:SEC_LO]),
        .bottom_i             (ctrl_r[CTRL_BOTTOM]),
        .sector_number_o      (sector_num)
    );

    // ==========================================================
    // Wishbone slave: ack one cycle after the request, write at the ack edge
    always_comb begin
        ack_nxt  = wb_cyc_i & wb_stb_i & ~ack_r;
        ctrl_nxt = ctrl_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        op_nxt   = OP_NONE;
        err_nxt  = err_r;
        dat_nxt  = dat_r;
        wmerge   = 32'h0000_0000;
        if (wb_cyc_i && wb_stb_i && wb_we_i && ack_r) begin
            case (wb_adr_i)
                REG_CTRL: begin
                    wmerge   = lane_merge({26'h0, ctrl_r, 3'h0}, wb_dat_i, wb_sel_i);
                    ctrl_nxt = wmerge[5:3];
                    op_nxt   = wmerge[CTRL_OP_LSB +: 3];
                end
                REG_ADDR: begin
                    wmerge   = lane_merge({14'h0, addr_r}, wb_dat_i, wb_sel_i);
                    addr_nxt = wmerge[ADDR_W-1:0];
                end
                REG_WDATA: begin
                    wmerge    = lane_merge({24'h0, wdata_r}, wb_dat_i, wb_sel_i);
                    wdata_nxt = wmerge[7:0];
                end
                REG_STATUS: begin
                    if (wb_sel_i[0] && wb_dat_i[ST_ERR]) begin
                        err_nxt = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // A refusal in the same cycle as a clear still leaves the flag set
        if (seq_err) begin
            err_nxt = 1'b1;
        end
        if (ack_nxt) begin
            case (wb_adr_i)
                REG_CTRL:   dat_nxt = {26'h0, ctrl_r, 3'h0};
                REG_ADDR:   dat_nxt = {14'h0, addr_r};
                REG_WDATA:  dat_nxt = {24'h0, wdata_r};
                REG_RDATA:  dat_nxt = {24'h0, rdata_r};
                REG_STATUS: dat_nxt = {25'h0, sector_num, idm_r, err_r, ready_busy_n_i,
                                       state_r != S_IDLE};
                default:    dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r  <= 3'h0;
            addr_r  <= '0;
            wdata_r <= 8'h00;
            err_r   <= 1'b0;
            ack_r   <= 1'b0;
            dat_r   <= 32'h0000_0000;
            op_r    <= OP_NONE;
        end else begin
            ctrl_r  <= ctrl_nxt;
            addr_r  <= addr_nxt;
            wdata_r <= wdata_nxt;
            err_r   <= err_nxt;
            ack_r   <= ack_nxt;
            dat_r   <= dat_nxt;
            op_r    <= op_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // ==========================================================
    // Pin sequencer; an operation asked for while busy is refused and flagged
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        pins_nxt  = pins_r;
        rdata_nxt = rdata_r;
        phase_nxt = phase_r;
        idm_nxt   = idm_r;
        seq_err   = 1'b0;
        step      = cmd_step(phase_r, wdata_r, ctrl_r[CTRL_HV_RST]);
        pins_nxt.hv_id  = ctrl_r[CTRL_HV_ID];
        case (state_r)
            S_IDLE: begin
                if (op_r == OP_READ) begin
                    pins_nxt.addr = addr_r;
                    pins_nxt.ce_n = 1'b0;
                    pins_nxt.oe_n = 1'b0;
                    cnt_nxt   = CNT_W'(ACC_CYC);
                    state_nxt = S_READ;
                end else if (op_r == OP_WRITE) begin
                    if (step[4]) begin
                        pins_nxt.addr    = addr_r;
                        pins_nxt.dq      = wdata_r;
                        pins_nxt.dq_oe_n = 1'b0;
                        pins_nxt.ce_n    = 1'b0;
                        state_nxt = S_WR_SET;
                    end else begin
                        seq_err   = 1'b1;
                        phase_nxt = PH_IDLE;
                    end
                end else if (op_r == OP_HRESET) begin
                    pins_nxt.rst_n = 1'b0;
                    cnt_nxt   = CNT_W'(RP_CYC);
                    state_nxt = S_RST_PULSE;
                end
            end
            S_READ: begin
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == CNT_W'(1)) begin
                    rdata_nxt     = dq_i;
                    pins_nxt.ce_n = 1'b1;
                    pins_nxt.oe_n = 1'b1;
                    state_nxt     = S_RD_END;
                end
            end
            S_WR_SET: begin
                pins_nxt.we_n = 1'b0;
                cnt_nxt   = CNT_W'(WP_CYC);
                state_nxt = S_WR_PULSE;
            end
            S_WR_PULSE: begin
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == CNT_W'(1)) begin
                    pins_nxt.we_n = 1'b1;
                    state_nxt     = S_WR_END;
                end
            end
            S_WR_END: begin
                pins_nxt.ce_n    = 1'b1;
                pins_nxt.dq_oe_n = 1'b1;
                phase_nxt = step[2:0];
                if (step[3]) begin
                    idm_nxt = 1'b1;
                end else if (phase_r == PH_IDLE && wdata_r == CMD_RESET) begin
                    idm_nxt = 1'b0;
                end
                state_nxt = S_IDLE;
            end
            S_RST_PULSE: begin
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == CNT_W'(1)) begin
                    pins_nxt.rst_n = 1'b1;
                    phase_nxt = PH_IDLE;
                    idm_nxt   = 1'b0;
                    state_nxt = S_RST_WAIT;
                end
            end
            S_RST_WAIT: begin
                if (ready_busy_n_i) begin
                    state_nxt = S_IDLE;
                end
            end
            S_RD_END: state_nxt = S_IDLE;
            default:  state_nxt = S_IDLE;
        endcase
        // Never ask for the elevated level while the reset pin is pulled low
        pins_nxt.hv_rst = ctrl_r[CTRL_HV_RST] & pins_nxt.rst_n;
        // Requests landing while busy are dropped, so software must poll busy
        if (state_r != S_IDLE && op_r != OP_NONE) begin
            seq_err = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= S_IDLE;
            cnt_r   <= '0;
            pins_r  <= PIN_RESET;
            rdata_r <= 8'h00;
            phase_r <= PH_IDLE;
            idm_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            pins_r  <= pins_nxt;
            rdata_r <= rdata_nxt;
            phase_r <= phase_nxt;
            idm_r   <= idm_nxt;
        end
    end

    assign pins_o = pins_r;

    // ==========================================================
    // Checks
    logic [CNT_W-1:0] low_cnt_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || (pins_r.oe_n && pins_r.we_n && pins_r.rst_n)) begin
            low_cnt_r <= '0;
        end else begin
            low_cnt_r <= low_cnt_r + 1'b1;
        end
    end

    sequence rst_released_s;
        state_r == S_RST_WAIT && ready_busy_n_i;
    endsequence

    read_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !pins_r.oe_n |-> !pins_r.ce_n && pins_r.we_n && pins_r.dq_oe_n)
        else $error("output enable low without a proper read setup");
    read_access_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(pins_r.oe_n) |-> low_cnt_r >= ACC_CYC && rdata_r == $past(dq_i))
        else $error("read ended before the access time");
    write_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !pins_r.we_n |-> !pins_r.ce_n && pins_r.oe_n && !pins_r.dq_oe_n)
        else $error("write strobe low without a proper write setup");
    write_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !pins_r.we_n && $past(!pins_r.we_n) |-> $stable(pins_r.addr) && $stable(pins_r.dq))
        else $error("address or data moved under the write strobe");
    write_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(pins_r.we_n) |-> low_cnt_r == WP_CYC ##1 pins_r.ce_n)
        else $error("write strobe width or release order wrong");
    bad_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == S_IDLE && op_r == OP_WRITE && !step[4] |=> err_r ##0 pins_r.we_n [*4])
        else $error("undefined command code reached the pins");
    reset_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(pins_r.rst_n) |-> low_cnt_r == RP_CYC)
        else $error("hard reset pulse has the wrong length");
    reset_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rst_released_s |=> state_r == S_IDLE ##0 pins_r.ce_n)
        else $error("sequencer did not return idle after ready");
    id_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == S_WR_END && phase_r == PH_UNL2 && wdata_r == CMD_IDENT |=> idm_r)
        else $error("identifier mode not tracked after its sequence");
    bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus acknowledge not a single cycle");

endmodule

// [testbench/pfbm_flash_model.sv]
// Behavioural byte-wide flash device on the far side of the controller pins.
// Assumes the pins change only after clk_i edges; top-boot sector layout only.
`timescale 1ns/1ps
module pfbm_flash_model
    import pfbm_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE  = 8'h3C,  // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h5A,  // Arbitrary value
    parameter logic [7:0] SUSP_STAT   = 8'h48,  // Status byte shown for an erasing sector
    parameter int         RP_MIN      = 12
)(
    input  wire logic         clk_i,
    input  wire pfbm_pin_type pins_i,
    output logic      [7:0]   dq_o,
    output logic              ready_busy_n_o
);
    logic [7:0]  mem [0:63];
    logic [6:0]  prot;
    logic [6:0]  ers;   // Sectors with an erase pending
    logic        susp;  // Erase suspended, read mode
    logic [2:0]  ph;
    logic [17:0] lat_a;
    logic        idm;
    logic        we_q;
    logic [7:0]  last;
    logic [7:0]  busy_cnt;
    int          rst_cnt;
    // ==========================================================
    // Decode and storage helpers; the array is folded to 64 bytes
    function automatic int sec(input logic [17:0] a);
        if (a[17:16] != 2'h3) return a[17:16];
        if (!a[15]) return 3;
        return a[14] ? 6 : (a[13] ? 5 : 4);
    endfunction
    function automatic int ix(input logic [17:0] a);
        return {a[17:15], a[2:0]};
    endfunction
    initial begin
        for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'hA5;
        {prot, ers, susp, ph, idm, we_q, last, busy_cnt, rst_cnt} = '0;
        we_q = 1'b1;
    end
    assign ready_busy_n_o = (busy_cnt == 8'h00);
    // Released lines show the inverse of the last byte, never a stale copy
    always_comb begin
        if (pins_i.ce_n || pins_i.oe_n || !pins_i.rst_n) dq_o = ~last;
        // Byte addresses: word line A0 is bit 1, A1 is bit 2
        else if (pins_i.hv_id && !pins_i.addr[2])
            dq_o = pins_i.addr[1] ? DEVICE_CODE : MAKER_CODE;
        else if (pins_i.hv_id) dq_o = {7'h00, prot[sec(pins_i.addr)]};
        else if (idm) dq_o = pins_i.addr[1] ? DEVICE_CODE : MAKER_CODE;
        else if (susp && ers[sec(pins_i.addr)]) dq_o = SUSP_STAT;
        else dq_o = mem[ix(pins_i.addr)];
    end
    // ==========================================================
    // Command decode: address on the falling strobe, data on its rising
    always @(posedge clk_i) begin
        we_q <= pins_i.we_n;
        if (!pins_i.ce_n && !pins_i.oe_n) last <= dq_o;
        if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
        rst_cnt <= pins_i.rst_n ? 0 : rst_cnt + 1;
        if (!pins_i.rst_n && rst_cnt >= RP_MIN) {ph, idm} <= '0;
        if (we_q && !pins_i.we_n && !pins_i.ce_n && pins_i.oe_n) lat_a <= pins_i.addr;
        if (!we_q && pins_i.we_n && !pins_i.ce_n && pins_i.rst_n) begin
            ph <= 3'h0;
            case (ph)
                3'h0: if (pins_i.dq == CMD_UNLOCK1) ph <= 3'h1;
                    else if (pins_i.dq == CMD_RESET && busy_cnt == 8'h00) idm <= 1'b0;
                    else if (pins_i.dq == CMD_PROT1 && pins_i.hv_rst) ph <= 3'h7;
                    else if (pins_i.dq == CMD_SUSPEND && |ers) {susp, busy_cnt} <= 9'h100;
                3'h1: if (pins_i.dq == CMD_UNLOCK2) ph <= 3'h2;
                3'h2: if (pins_i.dq == CMD_IDENT) idm <= 1'b1;
                    else if (pins_i.dq == CMD_PROG) ph <= 3'h3;
                    else if (pins_i.dq == CMD_ERASE) ph <= 3'h4;
                3'h4: if (pins_i.dq == CMD_UNLOCK1) ph <= 3'h5;
                3'h5: if (pins_i.dq == CMD_UNLOCK2) ph <= 3'h6;
                // Erase runs long so that a suspend can land inside it
                3'h6: if (pins_i.dq == CMD_SECTOR) {ers[sec(lat_a)], busy_cnt} <= 9'h1FF;
                3'h3: if (!prot[sec(lat_a)] || pins_i.hv_rst) begin
                    mem[ix(lat_a)] <= pins_i.dq;
                    busy_cnt <= 8'h08;
                end
                3'h7: if (pins_i.dq == CMD_PROT2) prot[sec(lat_a)] <= 1'b1;
                default: ;
            endcase
        end
    end
endmodule

// [testbench/pfbm_ctrl_tb_top.sv]
// Self-checking bench: Wishbone register access driving the controller and flash model.
// Assumes the behavioural flash model on the pin side and one 40 MHz clock.
`timescale 1ns/1ps
module pfbm_ctrl_tb_top
    import pfbm_pkg::*;
;
    logic         clk_i, rst_i, cyc, stb, we, ack, rb_n;
    logic [7:0]   adr, dq;
    logic [31:0]  wdat, rdat, q;
    pfbm_pin_type pins;
    int           failures, comparisons;
    logic         rbw = 1'b1;  // Poll also waits for the flash busy line
    logic [17:0]  sec_a [14] = '{18'h00000, 18'h1ABCD, 18'h2FFFF, 18'h30000, 18'h39FFF,
        18'h3A000, 18'h3FFFF, 18'h03FFF, 18'h04000, 18'h07FFF, 18'h08000, 18'h1FFFF,
        18'h20000, 18'h30000};
    pfbm_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pins_o(pins), .dq_i(dq), .ready_busy_n_i(rb_n));
    pfbm_flash_model flash (.clk_i(clk_i), .pins_i(pins), .dq_o(dq), .ready_busy_n_o(rb_n));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // ==========================================================
    // Bus tasks; every wait is bounded and a spent bound ends the run
    task automatic stop_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (n >= 20) failures++;
        if (n >= 20) stop_test();
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        cmp(nm, e, q);
    endtask
    // One flash bus action, then poll until the sequencer is idle and, while rbw is set, the flash too
    task automatic fop(input logic [2:0] op, input logic [17:0] a, input logic [7:0] d,
                       input logic [2:0] fl);
        int n;
        wb(1'b1, REG_ADDR, {14'h0, a});
        wb(1'b1, REG_WDATA, {24'h0, d});
        wb(1'b1, REG_CTRL, {26'h0, fl, op});
        n = 0;
        do begin
            wb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while ((q[0] !== 1'b0 || (rbw && q[1] !== 1'b1)) && n < 60);
        if (n >= 60) failures++;
        if (n >= 60) stop_test();
    endtask
    task automatic cmd3(input logic [7:0] c, input logic [2:0] fl);
        fop(OP_WRITE, 18'hAAA, CMD_UNLOCK1, fl);
        fop(OP_WRITE, 18'h555, CMD_UNLOCK2, fl);
        fop(OP_WRITE, 18'hAAA, c, fl);
    endtask
    task automatic frd(input logic [17:0] a, input logic [2:0] fl, input logic [7:0] e);
        fop(OP_READ, a, 8'h00, fl);
        rd("rdata", REG_RDATA, {24'h0, e});
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {rst_i, cyc, stb, we, adr, wdat, failures, comparisons} = '0;
        rst_i = 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("status", REG_STATUS, 32'h2);
        rd("ctrl", REG_CTRL, 32'h0);
        rd("unmapped", 8'h40, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 14; i++) begin
            wb(1'b1, REG_ADDR, {14'h0, sec_a[i]});
            wb(1'b1, REG_CTRL, {28'h0, i >= 7, 3'h0});
            wb(1'b0, REG_STATUS, 32'h0);
            cmp("sector", i % 7, {29'h0, q[6:4]});
        end
        $display("test decode done");
        frd(18'h10005, 3'h0, 8'hB0);
        cmd3(CMD_PROG, 3'h0);
        fop(OP_WRITE, 18'h20003, 8'h3E, 3'h0);
        frd(18'h20003, 3'h0, 8'h3E);
        fop(OP_WRITE, 18'h0, 8'h12, 3'h0);
        rd("status", REG_STATUS, 32'h6);
        wb(1'b1, REG_STATUS, 32'h4);
        rd("status", REG_STATUS, 32'h2);
        $display("test array done");
        cmd3(CMD_IDENT, 3'h0);
        rd("status", REG_STATUS, 32'hA);
        frd(18'h0, 3'h0, 8'h3C);
        frd(18'h2, 3'h0, 8'h5A);
        fop(OP_WRITE, 18'h0, CMD_RESET, 3'h0);
        frd(18'h10005, 3'h0, 8'hB0);
        cmd3(CMD_IDENT, 3'h0);
        fop(OP_HRESET, 18'h0, 8'h00, 3'h0);
        rd("status", REG_STATUS, 32'h2);
        frd(18'h10005, 3'h0, 8'hB0);
        $display("test ident done");
        frd(18'h0, 3'h4, 8'h3C);
        frd(18'h2, 3'h4, 8'h5A);
        frd(18'h4, 3'h4, 8'h00);
        fop(OP_WRITE, 18'h30000, CMD_PROT1, 3'h2);
        fop(OP_WRITE, 18'h30000, CMD_PROT2, 3'h2);
        frd(18'h30004, 3'h4, 8'h01);
        cmd3(CMD_PROG, 3'h0);
        fop(OP_WRITE, 18'h30001, 8'h77, 3'h0);
        frd(18'h30001, 3'h0, 8'h94);
        cmd3(CMD_PROG, 3'h2);
        fop(OP_WRITE, 18'h30001, 8'h77, 3'h2);
        frd(18'h30001, 3'h0, 8'h77);
        frd(18'h30004, 3'h4, 8'h01);
        $display("test protect done");
        rbw = 1'b0;
        cmd3(CMD_ERASE, 3'h0);
        cmd3(CMD_SECTOR, 3'h0);
        rd("status", REG_STATUS, 32'h0);
        fop(OP_WRITE, 18'h0, CMD_SUSPEND, 3'h0);
        rbw = 1'b1;
        rd("status", REG_STATUS, 32'h2);
        frd(18'h00005, 3'h0, 8'h48);
        frd(18'h10005, 3'h0, 8'hB0);
        cmd3(CMD_PROG, 3'h0);
        fop(OP_WRITE, 18'h20004, 8'h5C, 3'h0);
        frd(18'h20004, 3'h0, 8'h5C);
        frd(18'h00005, 3'h0, 8'h48);
        $display("test suspend done");
        stop_test();
    end
endmodule
